// [rtl/fps_pkg.sv]
// constants and state type for the flyback protection supervisor
package fps_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int TICK_NS = 1000000;
    localparam int CLK_NS = 1000000000 / CLK_HZ;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int TICKW = 16;
    localparam int MSW = 10;
    localparam logic [MSW-1:0] BROWNOUT_MS = 10'h01e;
    localparam logic [MSW-1:0] PAUSE_NORM_MS = 10'h006;
    localparam logic [MSW-1:0] PAUSE_BURST_MS = 10'h061;
    localparam logic [MSW-1:0] DISCONNECT_MS = 10'h01c;
    localparam logic [MSW-1:0] OPP_RUN_MS = 10'h0c8;
    localparam logic [MSW-1:0] OPP_START_MS = 10'h028;
    localparam logic [MSW-1:0] RESTART_MS = 10'h320;
    localparam int MAXON_NS = 55000;
    localparam int MAXON_CYC = MAXON_NS / CLK_NS;
    localparam int ONW = 12;
    localparam logic [2:0] OVP_PULSES = 3'h4;
    localparam int LVLW = 8;

    typedef enum logic [5:0] {
        FPS_WAIT = 6'h01,
        FPS_ARM = 6'h02,
        FPS_RUN = 6'h04,
        FPS_SAFE = 6'h08,
        FPS_LATCH = 6'h10,
        FPS_RECHK = 6'h20
    } fps_state_t;
endpackage

// [rtl/flyback_protection_supervisor.sv]
// protection and mains supervision logic of the flyback controller
`timescale 1ns/1ns
`default_nettype none
module flyback_protection_supervisor
    import fps_pkg::*;
#(
    parameter int LEVEL_W = LVLW
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // mains converter
    input wire logic [LEVEL_W-1:0] mainsLevel,
    input wire logic mainsValid,
    input wire logic [LEVEL_W-1:0] brownin_current_threshold,
    input wire logic [LEVEL_W-1:0] brownoutThreshold,
    input wire logic [LEVEL_W-1:0] mains_high_threshold,
    // comparators and status from the power stage
    input wire logic gateRequest,
    input wire logic overPeakLimit,
    input wire logic overOverpower,
    input wire logic auxOpen,
    input wire logic overcurrent,
    input wire logic output_overvoltage_trip,
    input wire logic supply_undervoltage_lockout,
    input wire logic thermalShutdown,
    input wire logic feedbackBelow5V,
    input wire logic feedbackBelowHalfV,
    input wire logic feedbackAtMin,
    // outputs
    output logic driverEnable,
    output logic driverPullLow,
    output logic mains_sense_pin,
    output logic convertStart,
    output logic auxInputPhase,
    output logic supplyRegulate,
    output logic feedbackSourceEnable,
    output logic softStartCharge,
    output logic fullPowerLimit,
    output logic brownoutFlag,
    output logic mainsPresent
);
    // two-flop synchronisers for all pin side inputs
    localparam int NS = 12;
    logic [NS-1:0] syncA, syncB;
    always_ff @(posedge ref_clk) begin
        syncA <= {mainsValid, gateRequest, overPeakLimit, overOverpower, auxOpen, overcurrent,
                  output_overvoltage_trip, supply_undervoltage_lockout, thermalShutdown,
                  feedbackBelow5V, feedbackBelowHalfV, feedbackAtMin};
        syncB <= syncA;
    end
    logic sValid, sGate, sPeak, sOpp, sAuxOpen, sOc, sOvp, sUvlo, sOtp, s5V, sHalf, sFbMin;
    assign {sValid, sGate, sPeak, sOpp, sAuxOpen, sOc, sOvp, sUvlo, sOtp, s5V, sHalf, sFbMin}
        = syncB;
    // level shares the valid's two-flop delay, so both line up at the sample
    logic [LEVEL_W-1:0] lvlA, lvlB;
    always_ff @(posedge ref_clk) begin
        lvlA <= mainsLevel;
        lvlB <= lvlA;
    end

    // millisecond tick
    logic [TICKW-1:0] tickCnt, next_tickCnt;
    logic tick;
    always_comb begin
        tick = (tickCnt == TICKW'(TICK_CYC - 1));
        next_tickCnt = tick ? '0 : tickCnt + 1'b1;
        if (rst) next_tickCnt = '0;
    end
    always_ff @(posedge ref_clk) tickCnt <= next_tickCnt;

    // mains sampling group
    logic [LEVEL_W-1:0] prevLvl, next_prevLvl;
    logic [MSW-1:0] pauseCnt, next_pauseCnt, lowCnt, next_lowCnt, slopeCnt, next_slopeCnt;
    logic sampling, next_sampling, convReq, next_convReq, present, next_present;
    logic brown, next_brown, above, next_above, disc, next_disc;
    logic rise;
    always_comb begin
        next_prevLvl = prevLvl;
        next_pauseCnt = pauseCnt;
        next_lowCnt = lowCnt;
        next_slopeCnt = slopeCnt;
        next_sampling = sampling;
        next_convReq = 1'b0;
        next_present = present;
        next_brown = brown;
        next_above = above;
        next_disc = disc;
        rise = ((prevLvl <= brownin_current_threshold) && (lvlB > brownin_current_threshold))
            || ((prevLvl <= mains_high_threshold) && (lvlB > mains_high_threshold));
        if (tick) begin
            if (pauseCnt != '0) next_pauseCnt = pauseCnt - 1'b1;
            else next_convReq = 1'b1;
            // disconnect on the tick that completes the slope timeout
            if (slopeCnt != DISCONNECT_MS - 1'b1) next_slopeCnt = slopeCnt + 1'b1;
            else begin
                next_disc = 1'b1;
                next_present = 1'b0;
            end
        end
        if (sValid && sampling) begin
            next_prevLvl = lvlB;
            next_above = lvlB > brownin_current_threshold;
            if (lvlB < brownoutThreshold) begin
                if (lowCnt != BROWNOUT_MS) next_lowCnt = lowCnt + 1'b1;
                if (lowCnt + 1'b1 >= BROWNOUT_MS) next_brown = 1'b1;
            end else begin
                next_lowCnt = '0;
                next_brown = 1'b0;
            end
            if (rise) begin
                next_present = 1'b1;
                next_disc = 1'b0;
                next_slopeCnt = '0;
                next_pauseCnt = sHalf ? PAUSE_BURST_MS : PAUSE_NORM_MS;
            end
        end
        next_sampling = (pauseCnt == '0) || disc;
        if (rst) begin
            next_prevLvl = '0;
            next_pauseCnt = '0;
            next_lowCnt = '0;
            next_slopeCnt = '0;
            next_sampling = 1'b0;
            next_present = 1'b0;
            next_brown = 1'b0;
            next_above = 1'b0;
            next_disc = 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        prevLvl <= next_prevLvl;
        pauseCnt <= next_pauseCnt;
        lowCnt <= next_lowCnt;
        slopeCnt <= next_slopeCnt;
        sampling <= next_sampling;
        convReq <= next_convReq;
        present <= next_present;
        brown <= next_brown;
        above <= next_above;
        disc <= next_disc;
    end

    // protection state machine group
    fps_state_t state, next_state;
    logic [MSW-1:0] msCnt, next_msCnt, oppCnt, next_oppCnt;
    logic [ONW-1:0] onCnt, next_onCnt;
    logic [2:0] ovpCnt, next_ovpCnt;
    logic gatePrev, next_gatePrev, inReg, next_inReg;
    logic cut, next_cut;
    logic gate, restartTrip, latchTrip, mainsGone;
    logic [MSW-1:0] oppLimit;
    always_comb begin
        next_state = state;
        next_msCnt = msCnt;
        next_oppCnt = oppCnt;
        next_onCnt = onCnt;
        next_ovpCnt = ovpCnt;
        next_gatePrev = sGate;
        // cut holds to the end of the request, so a falling peak cannot retrigger
        next_cut = sGate && (cut || sPeak || sOc);
        next_inReg = inReg;
        mainsGone = disc || !present;
        if (s5V) next_inReg = 1'b1;
        oppLimit = inReg ? OPP_RUN_MS : OPP_START_MS;
        gate = (state == FPS_RUN) && sGate && !cut && !sPeak && !sAuxOpen && !sOc;
        next_onCnt = gate ? onCnt + 1'b1 : '0;
        if (gate && tick && sOpp) next_oppCnt = oppCnt + 1'b1;
        else if (!sOpp && tick) next_oppCnt = '0;
        if (gatePrev && !sGate && state == FPS_RUN)
            next_ovpCnt = sOvp ? ((ovpCnt == OVP_PULSES) ? ovpCnt : ovpCnt + 1'b1) : '0;
        restartTrip = (onCnt == ONW'(MAXON_CYC))
            || (oppCnt >= oppLimit)
            || (sOpp && sUvlo);
        latchTrip = sOtp || (ovpCnt == OVP_PULSES);
        if (tick && msCnt != RESTART_MS) next_msCnt = msCnt + 1'b1;
        case (state)
            FPS_WAIT: if (above && !brown && !disc) begin
                next_state = FPS_ARM;
                next_msCnt = '0;
            end
            FPS_ARM: if (brown || disc) next_state = FPS_WAIT;
                else if (sFbMin) next_state = FPS_RUN;
            FPS_RUN: begin
                if (latchTrip) next_state = FPS_LATCH;
                else if (restartTrip) next_state = FPS_SAFE;
                else if (brown) next_state = FPS_WAIT;
                if (latchTrip || restartTrip || brown) begin
                    next_msCnt = '0;
                    next_oppCnt = '0;
                    next_ovpCnt = '0;
                    next_inReg = 1'b0;
                end
            end
            FPS_SAFE: if (msCnt == RESTART_MS || mainsGone) begin
                next_state = FPS_RECHK;
                next_msCnt = '0;
            end
            FPS_RECHK: if (sValid && sampling)
                next_state = (lvlB > brownin_current_threshold) ? FPS_ARM : FPS_WAIT;
            FPS_LATCH: if (mainsGone) next_state = FPS_WAIT;
            default: next_state = FPS_WAIT;
        endcase
        if (rst) begin
            next_state = FPS_WAIT;
            next_msCnt = '0;
            next_oppCnt = '0;
            next_onCnt = '0;
            next_ovpCnt = '0;
            next_gatePrev = 1'b0;
            next_cut = 1'b0;
            next_inReg = 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        state <= next_state;
        msCnt <= next_msCnt;
        oppCnt <= next_oppCnt;
        onCnt <= next_onCnt;
        ovpCnt <= next_ovpCnt;
        gatePrev <= next_gatePrev;
        cut <= next_cut;
        inReg <= next_inReg;
    end

    // registered outputs
    logic next_driverEnable;
    logic next_driverPullLow;
    logic next_mains_sense_pin;
    logic next_convertStart;
    logic next_auxInputPhase;
    logic next_supplyRegulate;
    logic next_feedbackSourceEnable;
    logic next_softStartCharge;
    logic next_fullPowerLimit;
    logic next_brownoutFlag;
    logic next_mainsPresent;
    always_comb begin
        next_driverEnable = gate && next_state == FPS_RUN;
        next_driverPullLow = !(gate && next_state == FPS_RUN);
        next_mains_sense_pin = convReq || disc;
        next_convertStart = convReq;
        next_auxInputPhase = gate;
        // stopped supply stays regulated except while the aux pin is open with inReg set
        next_supplyRegulate = (state != FPS_RUN && !sAuxOpen) || !inReg;
        next_feedbackSourceEnable = state == FPS_ARM || state == FPS_RUN;
        next_softStartCharge = state == FPS_ARM && sFbMin;
        next_fullPowerLimit = inReg;
        next_brownoutFlag = brown;
        next_mainsPresent = present;
        if (rst) begin
            next_driverEnable = 1'b0;
            next_driverPullLow = 1'b1;
            next_mains_sense_pin = 1'b0;
            next_convertStart = 1'b0;
            next_auxInputPhase = 1'b0;
            next_supplyRegulate = 1'b1;
            next_feedbackSourceEnable = 1'b0;
            next_softStartCharge = 1'b0;
            next_fullPowerLimit = 1'b0;
            next_brownoutFlag = 1'b0;
            next_mainsPresent = 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        driverEnable <= next_driverEnable;
        driverPullLow <= next_driverPullLow;
        mains_sense_pin <= next_mains_sense_pin;
        convertStart <= next_convertStart;
        auxInputPhase <= next_auxInputPhase;
        supplyRegulate <= next_supplyRegulate;
        feedbackSourceEnable <= next_feedbackSourceEnable;
        softStartCharge <= next_softStartCharge;
        fullPowerLimit <= next_fullPowerLimit;
        brownoutFlag <= next_brownoutFlag;
        mainsPresent <= next_mainsPresent;
    end
endmodule
`default_nettype wire

// [dv/fps_stage_model.sv]
// power stage model: answers each mains sample with a converter result
`timescale 1ns/1ns
`default_nettype none
module fps_stage_model #(
    parameter int W = 8
) (
    // from the supervisor
    input wire logic ref_clk,
    input wire logic convertStart,
    input wire logic mains_sense_pin,
    // bench control
    input wire logic mainsOn,
    // converter result
    output logic [W-1:0] mainsLevel,
    output logic mainsValid
);
    logic [1:0] dly = 2'h0;
    initial mainsValid = 1'b0;
    initial mainsLevel = '0;
    always @(posedge ref_clk) begin
        mainsValid <= (dly == 2'h1);
        // a level only exists in the one cycle that mainsValid is high
        if (dly == 2'h1) begin
            mainsLevel <= mainsOn ? 8'h80 : 8'h05;
        end else begin
            mainsLevel <= ~mainsLevel;
        end
        if (convertStart && mains_sense_pin) begin
            dly <= 2'h3;
        end else if (dly != 2'h0) begin
            dly <= dly - 2'h1;
        end
    end
endmodule
`default_nettype wire

// [dv/fps_checker_sva.sv]
// port assertions for the flyback protection supervisor
`timescale 1ns/1ns
`default_nettype none
module fps_checker_sva
    import fps_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // inputs watched
    input wire logic gateRequest,
    input wire logic overPeakLimit,
    input wire logic overOverpower,
    input wire logic supply_undervoltage_lockout,
    input wire logic thermalShutdown,
    // outputs watched
    input wire logic driverEnable,
    input wire logic driverPullLow,
    input wire logic mains_sense_pin,
    input wire logic convertStart,
    input wire logic supplyRegulate,
    input wire logic brownoutFlag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [16:0] gap;
    logic seen;
    logic [ONW-1:0] onCnt;
    // cycles since last sample and length of current gate pulse
    always_ff @(posedge ref_clk) begin
        if (rst || convertStart) begin
            gap <= '0;
        end else if (gap != '1) begin
            gap <= gap + 17'h1;
        end
        seen <= !rst && (seen || convertStart);
        onCnt <= driverEnable ? onCnt + 12'h001 : 12'h000;
    end
    drive_inverse_a: assert property (driverPullLow == !driverEnable)
        else $error("pull-low is not the inverse of driver enable");
    peak_cut_a: assert property (overPeakLimit |-> ##[0:3] !driverEnable)
        else $error("gate not cut after peak limit");
    thermal_stop_a: assert property (thermalShutdown |-> ##[0:3] !driverEnable)
        else $error("gate not stopped on thermal shutdown");
    thermal_latch_a: assert property ($rose(thermalShutdown) |-> ##4 (!driverEnable && supplyRegulate) [*8])
        else $error("no latched off state after thermal shutdown");
    opp_supply_undervoltage_lockout_a: assert property ((overOverpower && supply_undervoltage_lockout) |-> ##[0:4] !driverEnable)
        else $error("overpower with lockout did not stop the gate");
    no_request_a: assert property ((!gateRequest) [*4] |-> !driverEnable)
        else $error("gate on without request");
    sample_pulse_a: assert property (convertStart |-> mains_sense_pin ##1 !convertStart)
        else $error("sample request not a single pulled-down cycle");
    sample_gap_a: assert property ((convertStart && seen) |-> gap >= TICK_CYC - 1)
        else $error("samples closer than one tick");
    reset_values_a: assert property ($fell(rst) |-> (!driverEnable && supplyRegulate && !brownoutFlag))
        else $error("outputs not at reset values");
    on_limit_a: assert property (onCnt <= MAXON_CYC + 3)
        else $error("on-time exceeds its limit");
    no_gate_brownout_a: assert property (driverEnable |-> !brownoutFlag)
        else $error("switching during brownout");
    cover property ($rose(driverEnable));
    cover property ($rose(convertStart));
    cover property ($rose(thermalShutdown) ##4 supplyRegulate);
endmodule
bind flyback_protection_supervisor fps_checker_sva i_fps_checker_sva (
    .ref_clk(ref_clk), .rst(rst), .gateRequest(gateRequest), .overPeakLimit(overPeakLimit),
    .overOverpower(overOverpower), .supply_undervoltage_lockout(supply_undervoltage_lockout),
    .thermalShutdown(thermalShutdown), .driverEnable(driverEnable), .driverPullLow(driverPullLow),
    .mains_sense_pin(mains_sense_pin), .convertStart(convertStart),
    .supplyRegulate(supplyRegulate), .brownoutFlag(brownoutFlag));
`default_nettype wire

// [dv/tb.sv]
// self-checking testbench for the flyback protection supervisor
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) \
    tests_run++; \
    if ((got) !== (ex)) begin \
        error_cnt++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end
module tb
    import fps_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, mainsOn = 1'b0, gateRequest = 1'b0, overPeakLimit = 1'b0;
    logic overOverpower = 1'b0, auxOpen = 1'b0, overcurrent = 1'b0, thermalShutdown = 1'b0;
    logic output_overvoltage_trip = 1'b0, supply_undervoltage_lockout = 1'b0;
    logic feedbackBelow5V = 1'b0, feedbackBelowHalfV = 1'b0, feedbackAtMin = 1'b0;
    logic [LVLW-1:0] mainsLevel;
    logic mainsValid, driverEnable, driverPullLow, mains_sense_pin, convertStart, auxInputPhase;
    logic supplyRegulate, feedbackSourceEnable, softStartCharge, fullPowerLimit, brownoutFlag;
    logic mainsPresent;
    int error_cnt = 0;
    int tests_run = 0;
    always #10 ref_clk = ~ref_clk;
    flyback_protection_supervisor i_flyback_protection_supervisor (
        .ref_clk(ref_clk), .rst(rst), .mainsLevel(mainsLevel), .mainsValid(mainsValid),
        .brownin_current_threshold(8'h40), .brownoutThreshold(8'h30),
        .mains_high_threshold(8'hc0), .gateRequest(gateRequest), .overPeakLimit(overPeakLimit),
        .overOverpower(overOverpower), .auxOpen(auxOpen), .overcurrent(overcurrent),
        .output_overvoltage_trip(output_overvoltage_trip),
        .supply_undervoltage_lockout(supply_undervoltage_lockout),
        .thermalShutdown(thermalShutdown), .feedbackBelow5V(feedbackBelow5V),
        .feedbackBelowHalfV(feedbackBelowHalfV), .feedbackAtMin(feedbackAtMin),
        .driverEnable(driverEnable), .driverPullLow(driverPullLow),
        .mains_sense_pin(mains_sense_pin), .convertStart(convertStart),
        .auxInputPhase(auxInputPhase), .supplyRegulate(supplyRegulate),
        .feedbackSourceEnable(feedbackSourceEnable), .softStartCharge(softStartCharge),
        .fullPowerLimit(fullPowerLimit), .brownoutFlag(brownoutFlag), .mainsPresent(mainsPresent));
    fps_stage_model #(.W(LVLW)) i_fps_stage_model (
        .ref_clk(ref_clk), .convertStart(convertStart), .mains_sense_pin(mains_sense_pin),
        .mainsOn(mainsOn), .mainsLevel(mainsLevel), .mainsValid(mainsValid));
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    function automatic logic sel(input int k);
        case (k)
            0: return convertStart;
            1: return feedbackSourceEnable;
            default: return softStartCharge;
        endcase
    endfunction
    // bounded wait for an output to rise
    task automatic await(input string nm, input int k, input int lim);
        for (int i = 0; i < lim && sel(k) !== 1'b1; i++) begin
            step(1);
        end
        `CHK(nm, 1'b1, sel(k))
        if (sel(k) !== 1'b1) begin
            close_out();
        end
    endtask
    task automatic bring_up();
        rst = 1'b1;
        feedbackAtMin = 1'b0;
        feedbackBelow5V = 1'b0;
        step(6);
        `CHK("reset driver", 1'b0, driverEnable)
        `CHK("reset supply", 1'b1, supplyRegulate)
        rst = 1'b0;
        mainsOn = 1'b1;
        gateRequest = 1'b1;
        await("sample request", 0, TICK_CYC + 100);
        `CHK("pin pulled", 1'b1, mains_sense_pin)
        `CHK("no gate before brown-in", 1'b0, driverEnable)
        gateRequest = 1'b0;
        await("feedback sources", 1, 40);
        `CHK("mains present", 1'b1, mainsPresent)
        `CHK("no brownout", 1'b0, brownoutFlag)
        `CHK("no soft start early", 1'b0, softStartCharge)
        feedbackAtMin = 1'b1;
        await("soft start", 2, 20);
        gateRequest = 1'b1;
        step(5);
        `CHK("gate on", 1'b1, driverEnable)
        `CHK("pull-low off", 1'b0, driverPullLow)
        `CHK("aux input phase", 1'b1, auxInputPhase)
        $display("test bring_up done");
    endtask
    task automatic power_limits();
        feedbackBelow5V = 1'b1;
        step(6);
        `CHK("full power", 1'b1, fullPowerLimit)
        `CHK("regulation ends", 1'b0, supplyRegulate)
        overPeakLimit = 1'b1;
        overcurrent = 1'b1;
        step(4);
        `CHK("peak cut", 1'b0, driverEnable)
        overPeakLimit = 1'b0;
        overcurrent = 1'b0;
        step(4);
        `CHK("cut holds", 1'b0, driverEnable)
        gateRequest = 1'b0;
        step(4);
        gateRequest = 1'b1;
        step(5);
        `CHK("next cycle on", 1'b1, driverEnable)
        $display("test power_limits done");
    endtask
    task automatic opp_supply_undervoltage_lockout();
        overOverpower = 1'b1;
        supply_undervoltage_lockout = 1'b1;
        step(5);
        `CHK("protection at once", 1'b0, driverEnable)
        overOverpower = 1'b0;
        supply_undervoltage_lockout = 1'b0;
        step(20);
        `CHK("restart wait off", 1'b0, driverEnable)
        `CHK("restart supply", 1'b1, supplyRegulate)
        gateRequest = 1'b0;
        $display("test opp_supply_undervoltage_lockout done");
    endtask
    task automatic overvoltage();
        feedbackBelowHalfV = 1'b1;
        gateRequest = 1'b0;
        step(8);
        output_overvoltage_trip = 1'b1;
        for (int p = 0; p < 4; p++) begin
            gateRequest = 1'b1;
            step(8);
            `CHK("pulse before latch", 1'b1, driverEnable)
            gateRequest = 1'b0;
            step(8);
        end
        gateRequest = 1'b1;
        step(8);
        `CHK("latched off", 1'b0, driverEnable)
        `CHK("latch supply", 1'b1, supplyRegulate)
        gateRequest = 1'b0;
        thermalShutdown = 1'b1;
        auxOpen = 1'b1;
        step(6);
        `CHK("thermal off", 1'b0, driverEnable)
        thermalShutdown = 1'b0;
        auxOpen = 1'b0;
        step(2);
        $display("test overvoltage done");
    endtask
    initial begin
        bring_up();
        power_limits();
        opp_supply_undervoltage_lockout();
        bring_up();
        overvoltage();
        close_out();
    end
endmodule
`default_nettype wire
